// [imra_core.sv]
// I2C master: start, repeated start, stop, byte send, arbitration, bus monitor
`timescale 1ns/1ns
`include "imra_regs.svh"
module imra_core (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   moduleEnable,
  input  wire logic                   sleepMode,
  input  wire logic                   eventIrqEnable,
  input  wire logic [6:0]             baudReloadValue,
  input  wire logic                   ctrlWrValid,
  input  wire imra_pkg::imra_ctrl_s   ctrlWrData,
  input  wire logic                   bufWrValid,
  input  wire logic [7:0]             bufWrData,
  output      logic                   bufWrReady,
  input  wire logic                   portEventClr,
  input  wire logic                   busCollisionClr,
  input  wire logic                   writeCollisionClr,
  input  wire logic                   sdaIn,
  output      logic                   sdaOut,
  output      logic                   sdaOe,
  input  wire logic                   sclIn,
  output      logic                   sclOut,
  output      logic                   sclOe,
  output      imra_pkg::imra_ctrl_s   portControl,
  output      imra_pkg::imra_status_s portStatus,
  output      logic                   busFree,
  output      logic                   ackStatus,
  output      logic                   portEventFlag,
  output      logic                   busCollisionFlag,
  output      logic                   writeCollisionFlag,
  output      logic                   wakeRequest
);
  import imra_pkg::*;

  logic [1:0]  sdaSync_q;
  logic [1:0]  sclSync_q;
  logic        sdaS;
  logic        sclS;
  logic        sdaP_q;
  logic        sclP_q;
  logic        startDet;
  logic        stopDet;
  logic        startSeen_q;
  logic        stopSeen_q;
  imra_ctrl_s  ctrl_q;
  imra_state_e state_q;
  imra_state_e stateD;
  logic        sdaOe_q;
  logic        sdaOeD;
  logic        sclOe_q;
  logic        sclOeD;
  logic [6:0]  brgCnt_q;
  logic [6:0]  brgLoadVal;
  logic        brgLoad;
  logic        brgDone;
  logic        stretch;
  logic        collide;
  logic        byteDone;
  logic        txPop;
  logic        txValid;
  logic [7:0]  txData;
  logic [8:0]  shift_q;
  logic [3:0]  bitCnt_q;
  logic        ack_q;
  logic        ownBus_q;
  logic        evDone_q;
  logic        event_q;
  logic        busColl_q;
  logic        write_collision_flag_q;
  logic        wake_q;
  logic        rsActive;
  logic        cmdPending;
  logic        doneStart;
  logic        doneRs;
  logic        doneStop;

  // ----------------------------------------
  // Pin synchronisers and edge finding
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdaSync_q <= 2'h3;
      sclSync_q <= 2'h3;
      sdaP_q    <= 1'b1;
      sclP_q    <= 1'b1;
    end else begin
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaP_q    <= sdaS;
      sclP_q    <= sclS;
    end
  end

  assign sdaS     = sdaSync_q[1];
  assign sclS     = sclSync_q[1];
  assign startDet = sclS && sclP_q && sdaP_q && !sdaS;
  assign stopDet  = sclS && sclP_q && !sdaP_q && sdaS;

  // ----------------------------------------
  // Bus monitor
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startSeen_q <= 1'b0;
      stopSeen_q  <= 1'b0;
    end else if (!moduleEnable) begin
      startSeen_q <= 1'b0; // R16
      stopSeen_q  <= 1'b0; // R16
    end else if (startDet) begin
      startSeen_q <= 1'b1; // R8
      stopSeen_q  <= 1'b0;
    end else if (stopDet) begin
      stopSeen_q  <= 1'b1;
      startSeen_q <= 1'b0;
    end
  end

  // Free after a stop, or when nothing has been seen yet
  assign busFree = stopSeen_q || (!startSeen_q && !stopSeen_q); // R17

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  assign rsActive   = state_q inside {RS_SCL_LOW, RS_SDA_HIGH, RS_SCL_RISE, RS_BOTH_HIGH, RS_SDA_LOW};
  assign cmdPending = ctrl_q.startEnable || ctrl_q.repeatedStartEnable || ctrl_q.stopEnable;
  assign doneStart  = (state_q == ST_SDA_LOW) && brgDone;
  assign doneRs     = (state_q == RS_SDA_LOW) && brgDone;
  assign doneStop   = (state_q == SP_SDA_HIGH) && brgDone && sdaS;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `IMRA_CTRL_RESET;
    end else if (!moduleEnable) begin
      ctrl_q <= `IMRA_CTRL_RESET; // R15
    end else if (collide) begin
      ctrl_q.startEnable         <= 1'b0; // R20
      ctrl_q.repeatedStartEnable <= 1'b0; // R20
      ctrl_q.stopEnable          <= 1'b0; // R20
    end else begin
      if (doneStart) begin
        ctrl_q.startEnable <= 1'b0;
      end
      if (doneRs) begin
        ctrl_q.repeatedStartEnable <= 1'b0; // R7
      end
      if (doneStop) begin
        ctrl_q.stopEnable <= 1'b0;
      end
      // No queueing: the whole low field is locked during a restart
      if (ctrlWrValid && !rsActive) begin // R13
        ctrl_q.ackEnable     <= ctrlWrData.ackEnable;
        ctrl_q.receiveEnable <= ctrlWrData.receiveEnable;
        // Sequence bits only take while nothing runs
        if (state_q == IDLE && !cmdPending) begin // R1 R10
          ctrl_q.startEnable         <= ctrlWrData.startEnable;
          ctrl_q.repeatedStartEnable <= ctrlWrData.repeatedStartEnable;
          ctrl_q.stopEnable          <= ctrlWrData.stopEnable;
        end
      end
    end
  end

  // ----------------------------------------
  // Baud counter
  // ----------------------------------------
  // Holds while a slave stretches SCL low
  assign stretch = (state_q inside {TX_HIGH, SP_SCL_HIGH}) && !sclS;
  assign brgDone = (brgCnt_q == 7'h00);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brgCnt_q <= 7'h00;
    end else if (brgLoad) begin
      brgCnt_q <= brgLoadVal; // R3 R5
    end else if (!brgDone && !stretch) begin
      brgCnt_q <= brgCnt_q - 7'h01;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    stateD     = state_q;
    sdaOeD     = sdaOe_q;
    sclOeD     = sclOe_q;
    brgLoad    = 1'b0;
    brgLoadVal = baudReloadValue[`IMRA_BRG_LONG_MSB:0];
    collide    = 1'b0;
    byteDone   = 1'b0;
    txPop      = 1'b0;
    unique case (state_q)
      IDLE: begin
        if (ctrl_q.startEnable) begin
          sdaOeD  = 1'b0;
          sclOeD  = 1'b0;
          brgLoad = 1'b1;
          stateD  = ST_BOTH_HIGH;
        end else if (ctrl_q.repeatedStartEnable) begin
          sclOeD = 1'b1; // R2
          stateD = RS_SCL_LOW;
        end else if (ctrl_q.stopEnable) begin
          sdaOeD  = 1'b1;
          sclOeD  = 1'b1;
          brgLoad = 1'b1;
          stateD  = SP_SDA_LOW;
        end else if (txValid && ownBus_q) begin
          txPop   = 1'b1; // R22
          sdaOeD  = !txData[7];
          sclOeD  = 1'b1;
          brgLoad = 1'b1;
          stateD  = TX_LOW;
        end
      end
      ST_BOTH_HIGH: begin
        if (!sdaS || !sclS) begin
          collide = 1'b1; // R18
        end else if (brgDone) begin
          sdaOeD  = 1'b1;
          brgLoad = 1'b1;
          stateD  = ST_SDA_LOW;
        end
      end
      ST_SDA_LOW: begin
        if (brgDone) begin
          stateD = IDLE;
        end
      end
      RS_SCL_LOW: begin
        if (!sclS) begin
          sdaOeD     = 1'b0; // R3
          brgLoad    = 1'b1;
          brgLoadVal = {1'b0, baudReloadValue[`IMRA_BRG_SHORT_MSB:0]}; // R3
          stateD     = RS_SDA_HIGH;
        end
      end
      RS_SDA_HIGH: begin
        if (brgDone) begin
          if (sdaS) begin
            sclOeD = 1'b0; // R4
            stateD = RS_SCL_RISE;
          end else begin
            collide = 1'b1; // R18
          end
        end
      end
      RS_SCL_RISE: begin
        if (sclS) begin
          if (!sdaS) begin
            collide = 1'b1; // R11
          end else begin
            brgLoad = 1'b1; // R5
            stateD  = RS_BOTH_HIGH;
          end
        end
      end
      RS_BOTH_HIGH: begin
        if (!sclS || !sdaS) begin
          collide = 1'b1; // R11 R18
        end else if (brgDone) begin
          sdaOeD  = 1'b1; // R6
          brgLoad = 1'b1;
          stateD  = RS_SDA_LOW;
        end
      end
      RS_SDA_LOW: begin
        if (brgDone) begin
          stateD = IDLE; // R7
        end
      end
      SP_SDA_LOW: begin
        if (brgDone) begin
          sclOeD  = 1'b0;
          brgLoad = 1'b1;
          stateD  = SP_SCL_HIGH;
        end
      end
      SP_SCL_HIGH: begin
        if (sclS && brgDone) begin
          sdaOeD  = 1'b0;
          brgLoad = 1'b1;
          stateD  = SP_SDA_HIGH;
        end
      end
      SP_SDA_HIGH: begin
        if (!sdaS) begin
          collide = 1'b1; // R18
        end else if (brgDone) begin
          stateD = IDLE;
        end
      end
      TX_LOW: begin
        if (brgDone) begin
          sclOeD  = 1'b0;
          brgLoad = 1'b1;
          stateD  = TX_HIGH;
        end
      end
      TX_HIGH: begin
        // Ack slot is the slave's low, not a lost arbitration
        if (sclS && !sdaOe_q && !sdaS && bitCnt_q != `IMRA_LAST_BIT) begin
          collide = 1'b1; // R18
        end else if (sclS && brgDone) begin
          sclOeD = 1'b1;
          if (bitCnt_q == `IMRA_LAST_BIT) begin
            byteDone = 1'b1;
            stateD   = IDLE;
          end else begin
            sdaOeD  = !shift_q[7];
            brgLoad = 1'b1;
            stateD  = TX_LOW;
          end
        end
      end
      default: begin
        stateD = IDLE;
      end
    endcase
    if (!moduleEnable) begin
      collide = 1'b0;
    end
    if (collide || !moduleEnable) begin
      stateD = IDLE; // R15 R19 R20
      sdaOeD = 1'b0;
      sclOeD = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
      sdaOe_q <= 1'b0;
      sclOe_q <= 1'b0;
    end else begin
      state_q <= stateD;
      sdaOe_q <= sdaOeD;
      sclOe_q <= sclOeD;
    end
  end

  // ----------------------------------------
  // Shifter, bit count, ownership
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q  <= 9'h1FF;
      bitCnt_q <= 4'h0;
      ack_q    <= 1'b1;
    end else if (txPop) begin
      shift_q  <= {txData, 1'b1}; // R22
      bitCnt_q <= 4'h0;
    end else if (state_q == TX_HIGH && stateD == TX_LOW) begin
      shift_q  <= {shift_q[7:0], 1'b1};
      bitCnt_q <= bitCnt_q + 4'h1;
    end else if (byteDone) begin
      ack_q <= sdaS;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ownBus_q <= 1'b0;
    end else if (collide || !moduleEnable || doneStop) begin
      ownBus_q <= 1'b0;
    end else if (doneStart || doneRs) begin
      ownBus_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  imra_buffer #(
    .WIDTH (`IMRA_BYTE_BITS),
    .DEPTH (2)
  ) u_buffer (
    .clk      (clk),
    .resetn   (resetn),
    .flush    (collide || !moduleEnable), // R19
    .inValid  (bufWrValid && !rsActive && moduleEnable), // R12
    .inData   (bufWrData),
    .inReady  (bufWrReady),
    .outValid (txValid),
    .outData  (txData),
    .outReady (txPop)
  );

  // ----------------------------------------
  // Flags: set wins over software clear
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evDone_q <= 1'b0;
      event_q  <= 1'b0;
    end else begin
      evDone_q <= doneStart || doneRs || doneStop || byteDone; // R9
      if (evDone_q || (stopDet && moduleEnable)) begin
        event_q <= 1'b1; // R17 R21 R23
      end else if (portEventClr) begin
        event_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busColl_q <= 1'b0;
      write_collision_flag_q    <= 1'b0;
    end else begin
      if (collide) begin
        busColl_q <= 1'b1; // R18 R23
      end else if (busCollisionClr) begin
        busColl_q <= 1'b0;
      end
      if (bufWrValid && rsActive && moduleEnable) begin
        write_collision_flag_q <= 1'b1; // R12
      end else if (writeCollisionClr) begin
        write_collision_flag_q <= 1'b0;
      end
    end
  end

  // Any set event flag wakes: start, restart, stop, bus stop or sent byte; receive-side matching lives elsewhere
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleepMode && eventIrqEnable && event_q; // R14
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sdaOut             = 1'b0;
  assign sclOut             = 1'b0;
  assign sdaOe              = sdaOe_q;
  assign sclOe              = sclOe_q;
  assign portControl        = ctrl_q;
  assign portStatus         = '{stopSeen: stopSeen_q, startSeen: startSeen_q,
                                bufferFull: txValid || state_q inside {TX_LOW, TX_HIGH}}; // R19
  assign ackStatus          = ack_q;
  assign portEventFlag      = event_q;
  assign busCollisionFlag   = busColl_q;
  assign writeCollisionFlag = write_collision_flag_q;
  assign wakeRequest        = wake_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rs_ignore_a: assert property ((state_q != IDLE && !rsActive && ctrlWrValid && moduleEnable) // R10
    |=> !$rose(ctrl_q.repeatedStartEnable)) else $error("restart enable taken while busy");
  rs_scl_low_a: assert property ((state_q == RS_SCL_LOW) |-> sclOe_q) // R2
    else $error("SCL not pulled low at restart");
  rs_load_a: assert property ((state_q == RS_SCL_LOW && !sclS && moduleEnable) // R3
    |=> brgCnt_q == {1'b0, $past(baudReloadValue[5:0])} && !sdaOe_q) else $error("short reload wrong");
  rs_reload_a: assert property ((state_q == RS_SCL_RISE && sclS && sdaS && moduleEnable) // R5
    |=> brgCnt_q == $past(baudReloadValue) && state_q == RS_BOTH_HIGH) else $error("long reload wrong");
  rs_sda_low_a: assert property ((state_q == RS_SDA_LOW) |-> sdaOe_q && !sclOe_q) // R6
    else $error("restart hold wrong");
  rs_end_a: assert property ((doneRs && moduleEnable) // R7
    |=> !ctrl_q.repeatedStartEnable && sdaOe_q ##1 event_q) else $error("restart end wrong");
  rs_event_a: assert property ((rsActive && !event_q && !stopDet) |=> !event_q) // R9
    else $error("event before restart end");
  write_coll_a: assert property ((bufWrValid && rsActive && moduleEnable && !collide) // R12
    |=> write_collision_flag_q && $stable(txValid)) else $error("write collision missed");
  ctrl_lock_a: assert property ((rsActive && ctrlWrValid && moduleEnable) // R13
    |=> $stable({ctrl_q.ackEnable, ctrl_q.receiveEnable})) else $error("control written in restart");
  start_seen_a: assert property ((startDet && moduleEnable) |=> startSeen_q) // R8
    else $error("start not seen");
  disable_clr_a: assert property (!moduleEnable |=> !startSeen_q && !stopSeen_q) // R16
    else $error("seen bits kept while disabled");
  collide_idle_a: assert property (collide // R18
    |=> state_q == IDLE && busColl_q && !sdaOe_q && !sclOe_q && !txValid) else $error("collision not handled");
  stop_event_a: assert property ((stopDet && moduleEnable) |=> event_q) // R21
    else $error("stop missed");

  rs_done_c: cover property (doneRs);
  collide_c: cover property (collide && rsActive);
  byte_done_c: cover property (byteDone);
  write_coll_c: cover property (bufWrValid && rsActive);

endmodule

// [imra_regs.svh]
// Constants for the I2C master repeated-start and arbitration block
// How it works
// R1 - Repeated start begins only when software sets its enable bit while idle.
// R2 - Setting repeated-start enable first pulls SCL low.
// R3 - Once SCL reads low, load counter from reload bits 5:0 and release SDA.
// R4 - On counter expiry with SDA high, release SCL.
// R5 - With SCL high, reload from bits 6:0; both lines must stay high one period.
// R6 - Then pull SDA low for one baud period while SCL stays high.
// R7 - At the end clear the enable bit, stop reloading, keep SDA low.
// R8 - Start-seen status bit sets as soon as a start appears on the bus.
// R9 - Event flag for repeated start rises only after the final baud period.
// R10 - Repeated-start enable written while another event runs is ignored.
// R11 - Collision if SDA low as SCL rises, or SCL falls before SDA pulled low.
// R12 - Buffer write during repeated start sets write collision, buffer unchanged.
// R13 - Low five control bits cannot be written during a repeated start.
// R14 - While asleep, a completed byte wakes the processor if interrupts enabled.
// R15 - Reset or disable aborts any transfer and disables the module.
// R16 - Start-seen and stop-seen clear on reset and while disabled.
// R17 - Bus free when stop seen or neither seen; next stop raises event.
// R18 - Driving one but reading zero with SCL high sets collision, go idle.
// R19 - Collision during transmit halts it, clears buffer full, releases lines.
// R20 - Collision during start, restart or stop aborts it and clears its bits.
// R21 - After collision keep watching the bus; a stop raises the event flag.
// R22 - A buffer write after collision transmits from the first data bit; the code holds it until a later start or restart completes.
// R23 - Event and collision flags are separate levels held until software clears.
`ifndef IMRA_REGS_SVH
`define IMRA_REGS_SVH

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define IMRA_CTRL_RESET     5'h00
`define IMRA_BRG_SHORT_MSB  5
`define IMRA_BRG_LONG_MSB   6
`define IMRA_STATUS_START   3
`define IMRA_STATUS_STOP    4

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define IMRA_LAST_BIT       4'h8
`define IMRA_BYTE_BITS      8

`endif

// [imra_pkg.sv]
// Types shared by the I2C master repeated-start and arbitration block
package imra_pkg;

  // ----------------------------------------
  // Low five bits of port_control_2
  // ----------------------------------------
  typedef struct packed {
    logic ackEnable;
    logic receiveEnable;
    logic stopEnable;
    logic repeatedStartEnable;
    logic startEnable;
  } imra_ctrl_s;

  // ----------------------------------------
  // Status seen by software
  // ----------------------------------------
  typedef struct packed {
    logic stopSeen;
    logic startSeen;
    logic bufferFull;
  } imra_status_s;

  typedef enum logic [3:0] {
    IDLE, ST_BOTH_HIGH, ST_SDA_LOW,
    RS_SCL_LOW, RS_SDA_HIGH, RS_SCL_RISE, RS_BOTH_HIGH, RS_SDA_LOW,
    SP_SDA_LOW, SP_SCL_HIGH, SP_SDA_HIGH,
    TX_LOW, TX_HIGH
  } imra_state_e;

endpackage

// [imra_buffer.sv]
// Two-entry valid/ready buffer in front of the transmitter
`timescale 1ns/1ns
module imra_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             inReady,
  output      logic             outValid,
  output      logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady && !flush;
  assign pop      = outValid && outReady && !flush;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Data storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= nextPtr(wrPtr_q);
      end
      if (pop) begin
        rdPtr_q <= nextPtr(rdPtr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// [imra_bus_model.sv]
// Pull-up wires with an acknowledging slave on them
`timescale 1ns/1ns
module imra_bus_model (
  input  wire logic       sdaOe,
  input  wire logic       sclOe,
  input  wire logic       xSda,
  output      logic       sda,
  output      logic       scl,
  output      logic [7:0] rxByte
);
  logic [3:0] bitCnt = 4'hF;
  logic [7:0] sh     = 8'h00;
  logic       ackOe  = 1'b0;
  // Released lines float high
  assign sda = !(sdaOe | ackOe | xSda);
  assign scl = !sclOe;
  always @(negedge sda) if (scl) bitCnt = 4'h0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    // Latched whole, so the next byte cannot smear it
    if (bitCnt == 4'h7) rxByte = sh;
    if (bitCnt != 4'hF) bitCnt = bitCnt + 4'h1;
  end
  always @(negedge scl) begin
    ackOe = (bitCnt == 4'h8);
    if (bitCnt == 4'h9) bitCnt = 4'h0;
  end
endmodule

// [test_imra_core.sv]
// Self-checking bench for the I2C master core
`timescale 1ns/1ns
`define CHK(n, e, a) begin checksDone++; if ((a) !== (e)) begin failCount++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module test_imra_core;
  import imra_pkg::*;
  logic         clk    = 1'b0;
  logic         resetn = 1'b0;
  logic         en     = 1'b1;
  logic         slp    = 1'b0;
  logic         cwV    = 1'b0;
  logic         bwV    = 1'b0;
  logic         clr    = 1'b0;
  logic         xSda   = 1'b0;
  logic [6:0]   brv    = 7'h03;
  logic         ack;
  logic [7:0]   bwD    = 8'h00;
  logic [15:0]  lfsr   = 16'h94ED;
  imra_ctrl_s   cwD    = 5'h00;
  imra_ctrl_s   ctl;
  imra_status_s stat;
  logic         sda, scl, sdaOe, sclOe, ready, free, evFlag, bcFlag, wcFlag, wake;
  logic [7:0]   rxByte;
  logic [7:0]   expB [3];
  int           failCount, checksDone, cyc;

  imra_core uut (
    .clk                (clk),
    .resetn             (resetn),
    .moduleEnable       (en),
    .sleepMode          (slp),
    .eventIrqEnable     (1'b1),
    .baudReloadValue    (brv),
    .ctrlWrValid        (cwV),
    .ctrlWrData         (cwD),
    .bufWrValid         (bwV),
    .bufWrData          (bwD),
    .bufWrReady         (ready),
    .portEventClr       (clr),
    .busCollisionClr    (clr),
    .writeCollisionClr  (clr),
    .sdaIn              (sda),
    .sdaOut             (),
    .sdaOe              (sdaOe),
    .sclIn              (scl),
    .sclOut             (),
    .sclOe              (sclOe),
    .portControl        (ctl),
    .portStatus         (stat),
    .busFree            (free),
    .ackStatus          (ack),
    .portEventFlag      (evFlag),
    .busCollisionFlag   (bcFlag),
    .writeCollisionFlag (wcFlag),
    .wakeRequest        (wake)
  );
  imra_bus_model bus (.sdaOe(sdaOe), .sclOe(sclOe), .xSda(xSda), .sda(sda), .scl(scl), .rxByte(rxByte));

  always #20 clk = ~clk;
  // Whole run needs well under a thousand cycles
  always @(posedge clk) if (++cyc > 6000) begin failCount++; conclude; end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] nextRand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic ctrl(input imra_ctrl_s v);
    cwD = v;
    cwV = 1'b1;
    tick(1);
    cwV = 1'b0;
  endtask
  // Leaves valid high so back-to-back pushes never toggle it in one step
  task automatic push(input logic [7:0] b);
    bwD = b;
    bwV = 1'b1;
    for (int i = 0; i < 900 && ready !== 1'b1; i++) tick(1);
    tick(1);
  endtask
  task automatic waitEv;
    for (int i = 0; i < 900 && evFlag !== 1'b1; i++) tick(1);
    tick(2);
    `CHK("event", 1'b1, evFlag)
    `CHK("wake", slp, wake)
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(8);
    resetn = 1'b1;
    `CHK("free", 1'b1, free)
    ctrl(5'h01);
    tick(1);
    ctrl(5'h02);
    waitEv;
    `CHK("ctl", 5'h00, ctl)
    `CHK("start", 1'b1, stat.startSeen)
    `CHK("free", 1'b0, free)
    $display("start test done");
    // Bit 6 set so the short and long reloads differ
    brv = 7'h43;
    ctrl(5'h02);
    tick(1);
    `CHK("sclOe", 1'b1, sclOe)
    push(8'hA5);
    bwV = 1'b0;
    ctrl(5'h18);
    `CHK("write_collision_flag", 1'b1, wcFlag)
    `CHK("ctl", 5'h02, ctl)
    `CHK("full", 1'b0, stat.bufferFull)
    `CHK("early", 1'b0, evFlag)
    tick(6);
    `CHK("sclRise", 1'b1, scl)
    tick(40);
    `CHK("rsHold", 1'b0, sdaOe)
    waitEv;
    `CHK("ctl", 5'h00, ctl)
    `CHK("sdaOe", 1'b1, sdaOe)
    brv = 7'h03;
    $display("restart test done");
    slp = 1'b1;
    for (int k = 0; k < 3; k++) begin
      lfsr = nextRand(lfsr);
      expB[k] = lfsr[7:0];
      push(lfsr[7:0]);
    end
    bwV = 1'b0;
    `CHK("ready", 1'b0, ready)
    for (int k = 0; k < 3; k++) begin
      waitEv;
      `CHK("byte", expB[k], rxByte)
      `CHK("ack", 1'b0, ack)
    end
    slp = 1'b0;
    $display("byte test done");
    push(8'hFF);
    bwV = 1'b0;
    for (int i = 0; i < 900 && !(scl === 1'b1 && sdaOe === 1'b0); i++) tick(1);
    xSda = 1'b1;
    tick(4);
    `CHK("bcol", 1'b1, bcFlag)
    `CHK("lines", 2'b00, {sdaOe, sclOe})
    `CHK("full", 1'b0, stat.bufferFull)
    `CHK("ready", 1'b1, ready)
    xSda = 1'b0;
    tick(6);
    `CHK("stopEv", 1'b1, evFlag)
    `CHK("stop", 1'b1, stat.stopSeen)
    `CHK("free", 1'b1, free)
    waitEv;
    `CHK("bclr", 1'b0, bcFlag)
    $display("collision test done");
    // Another master holds SDA low through a restart
    xSda = 1'b1;
    ctrl(5'h02);
    tick(10);
    `CHK("rsColl", 1'b1, bcFlag)
    `CHK("ctl", 5'h00, ctl)
    xSda = 1'b0;
    waitEv;
    $display("restart collision test done");
    ctrl(5'h01);
    waitEv;
    lfsr = nextRand(lfsr);
    push(lfsr[7:0]);
    bwV = 1'b0;
    waitEv;
    `CHK("byte", lfsr[7:0], rxByte)
    en = 1'b0;
    tick(2);
    `CHK("seen", 2'b00, {stat.stopSeen, stat.startSeen})
    `CHK("lines", 2'b00, {sdaOe, sclOe})
    $display("disable test done");
    en = 1'b1;
    ctrl(5'h04);
    waitEv;
    `CHK("stop", 1'b1, stat.stopSeen)
    `CHK("ctl", 5'h00, ctl)
    $display("stop test done");
    conclude;
  end
endmodule
